// ===== inc/ccd_pkg.sv
package ccd_pkg;
  // feedback source select codes
  localparam logic [1:0] FB_SEL_GROUND  = 2'h0;
  localparam logic [1:0] FB_SEL_VCO     = 2'h1;
  localparam logic [1:0] FB_SEL_VCO_DLY = 2'h2;
  localparam logic [1:0] FB_SEL_RSVD    = 2'h3;
  // glitchless mux configurations
  localparam logic [1:0] GMX_CFG_A_C    = 2'h0;
  localparam logic [1:0] GMX_CFG_A_INT  = 2'h1;
  localparam logic [1:0] GMX_CFG_C_INT  = 2'h2;
  localparam logic [1:0] GMX_CFG_RSVD   = 2'h3;
  // glitchless mux chosen source encoding
  localparam logic [1:0] GMX_SRC_A      = 2'h0;
  localparam logic [1:0] GMX_SRC_C      = 2'h1;
  localparam logic [1:0] GMX_SRC_INT    = 2'h2;
  localparam logic [1:0] GMX_SRC_NONE   = 2'h3;
  // oscillator source encoding
  localparam logic [1:0] OSC_SRC_PIN    = 2'h0;
  localparam logic [1:0] OSC_SRC_RC     = 2'h1;
  localparam logic [1:0] OSC_SRC_XTAL   = 2'h2;
  // delay table in ps: base, step, code 0 of global outputs
  localparam int DLY_CODE_W       = 5;
  localparam int DLY_BASE_PS      = 600;
  localparam int DLY_STEP_PS      = 160;
  localparam int DLY_GL_CODE0_PS  = 225;
  localparam int DLY_MAX_PS       = 5560;
  localparam int DLY_PS_W         = 13;
endpackage

// ===== logic/ccd_delay_decode.sv
`timescale 1ns/100ps
module ccd_delay_decode #(
  parameter bit GLOBAL_TYPE = 1'b0
) (
  input  wire logic [4:0]  code,
  output logic      [12:0] delay_ps
);
  // ****************************************
  // code to typical delay
  // ****************************************
  // step 160 ps, code 31 reaches the 5.56 ns end point; global code 0 is shorter
  always_comb begin
    if (GLOBAL_TYPE && code == 5'h00) begin
      delay_ps = 13'(ccd_pkg::DLY_GL_CODE0_PS);
    end else begin
      delay_ps = 13'(ccd_pkg::DLY_BASE_PS + int'(code) * ccd_pkg::DLY_STEP_PS);
    end
  end
endmodule

// ===== logic/ccd_config_decode.sv
`timescale 1ns/100ps
// Functional notes
// - feedback select 0 passes ground, flagging power-down.
// - feedback select 1 undelayed vco phase, 2 delayed phase, 3 invalid.
// - feedback and secondary delay codes rise monotonically, 600 ps to 5.56 ns.
// - global delay codes rise monotonically, 225 ps at code 0 to 5.56 ns.
// - with path a select 1, input a source rc when 0, crystal when 1.
// - with shared path b/c select 1, inputs b and c choose rc or crystal.
// - glitchless config sets pair: a/c, a/internal, c/internal.
module ccd_config_decode (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [1:0]  feedback_source_select,
  input  wire logic [4:0]  feedback_delay_code,
  input  wire logic [4:0]  secondary_b_delay_code,
  input  wire logic [4:0]  secondary_c_delay_code,
  input  wire logic [4:0]  global_a_delay_code,
  input  wire logic [4:0]  global_b_delay_code,
  input  wire logic [4:0]  global_c_delay_code,
  input  wire logic        osc_path_a_select,
  input  wire logic        osc_path_bc_select,
  input  wire logic        dyn_source_a_select,
  input  wire logic        dyn_source_b_select,
  input  wire logic        dyn_source_c_select,
  input  wire logic [1:0]  glitchless_mux_config,
  input  wire logic        glitchless_out_mux,
  output logic             fb_ground_ff,
  output logic             fb_vco_ff,
  output logic             fb_vco_dly_ff,
  output logic             fb_invalid_ff,
  output logic             power_down_ff,
  output logic [12:0]      fb_delay_ps_ff,
  output logic [12:0]      yb_delay_ps_ff,
  output logic [12:0]      yc_delay_ps_ff,
  output logic [12:0]      gl_a_delay_ps_ff,
  output logic [12:0]      gl_b_delay_ps_ff,
  output logic [12:0]      gl_c_delay_ps_ff,
  output logic [1:0]       ref_input_a_src_ff,
  output logic [1:0]       ref_input_b_src_ff,
  output logic [1:0]       ref_input_c_src_ff,
  output logic [1:0]       gmux_src_ff,
  output logic             gmux_cfg_invalid_ff
);
  // ****************************************
  // feedback multiplexer
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fb_ground_ff  <= 1'b1;
      fb_vco_ff     <= 1'b0;
      fb_vco_dly_ff <= 1'b0;
      fb_invalid_ff <= 1'b0;
      power_down_ff <= 1'b1;
    end else if (clk_en) begin
      fb_ground_ff  <= feedback_source_select == ccd_pkg::FB_SEL_GROUND;
      power_down_ff <= feedback_source_select == ccd_pkg::FB_SEL_GROUND;
      fb_vco_ff     <= feedback_source_select == ccd_pkg::FB_SEL_VCO;
      fb_vco_dly_ff <= feedback_source_select == ccd_pkg::FB_SEL_VCO_DLY;
      // reserved code is flagged, never routed, so nothing toggles feedback
      fb_invalid_ff <= feedback_source_select == ccd_pkg::FB_SEL_RSVD;
    end
  end

  // ****************************************
  // delay lines
  // ****************************************
  logic [4:0]  dly_code [6];
  logic [12:0] dly_ps   [6];
  assign dly_code[0] = feedback_delay_code;
  assign dly_code[1] = secondary_b_delay_code;
  assign dly_code[2] = secondary_c_delay_code;
  assign dly_code[3] = global_a_delay_code;
  assign dly_code[4] = global_b_delay_code;
  assign dly_code[5] = global_c_delay_code;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_dly
      ccd_delay_decode #(
        .GLOBAL_TYPE (gi >= 3)
      ) u_dec (
        .code     (dly_code[gi]),
        .delay_ps (dly_ps[gi])
      );
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fb_delay_ps_ff  <= 13'(ccd_pkg::DLY_BASE_PS);
      yb_delay_ps_ff  <= 13'(ccd_pkg::DLY_BASE_PS);
      yc_delay_ps_ff  <= 13'(ccd_pkg::DLY_BASE_PS);
      gl_a_delay_ps_ff <= 13'(ccd_pkg::DLY_GL_CODE0_PS);
      gl_b_delay_ps_ff <= 13'(ccd_pkg::DLY_GL_CODE0_PS);
      gl_c_delay_ps_ff <= 13'(ccd_pkg::DLY_GL_CODE0_PS);
    end else if (clk_en) begin
      fb_delay_ps_ff  <= dly_ps[0];
      yb_delay_ps_ff  <= dly_ps[1];
      yc_delay_ps_ff  <= dly_ps[2];
      gl_a_delay_ps_ff <= dly_ps[3];
      gl_b_delay_ps_ff <= dly_ps[4];
      gl_c_delay_ps_ff <= dly_ps[5];
    end
  end

  // ****************************************
  // oscillator source selection
  // ****************************************
  // path select low leaves the input on its own pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ref_input_a_src_ff <= ccd_pkg::OSC_SRC_PIN;
      ref_input_b_src_ff <= ccd_pkg::OSC_SRC_PIN;
      ref_input_c_src_ff <= ccd_pkg::OSC_SRC_PIN;
    end else if (clk_en) begin
      ref_input_a_src_ff <= !osc_path_a_select ? ccd_pkg::OSC_SRC_PIN :
        (dyn_source_a_select ? ccd_pkg::OSC_SRC_XTAL : ccd_pkg::OSC_SRC_RC);
      ref_input_b_src_ff <= !osc_path_bc_select ? ccd_pkg::OSC_SRC_PIN :
        (dyn_source_b_select ? ccd_pkg::OSC_SRC_XTAL : ccd_pkg::OSC_SRC_RC);
      ref_input_c_src_ff <= !osc_path_bc_select ? ccd_pkg::OSC_SRC_PIN :
        (dyn_source_c_select ? ccd_pkg::OSC_SRC_XTAL : ccd_pkg::OSC_SRC_RC);
    end
  end

  // ****************************************
  // glitchless output multiplexer
  // ****************************************
  logic [1:0] nxt_gmux_src;
  always_comb begin
    unique case (glitchless_mux_config)
      ccd_pkg::GMX_CFG_A_C: begin
        nxt_gmux_src = glitchless_out_mux ? ccd_pkg::GMX_SRC_C : ccd_pkg::GMX_SRC_A;
      end
      ccd_pkg::GMX_CFG_A_INT: begin
        nxt_gmux_src = glitchless_out_mux ? ccd_pkg::GMX_SRC_INT : ccd_pkg::GMX_SRC_A;
      end
      ccd_pkg::GMX_CFG_C_INT: begin
        nxt_gmux_src = glitchless_out_mux ? ccd_pkg::GMX_SRC_INT : ccd_pkg::GMX_SRC_C;
      end
      ccd_pkg::GMX_CFG_RSVD: begin
        nxt_gmux_src = ccd_pkg::GMX_SRC_NONE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gmux_src_ff         <= ccd_pkg::GMX_SRC_A;
      gmux_cfg_invalid_ff <= 1'b0;
    end else if (clk_en) begin
      gmux_src_ff         <= nxt_gmux_src;
      gmux_cfg_invalid_ff <= glitchless_mux_config == ccd_pkg::GMX_CFG_RSVD;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_fb_ground_pd: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && feedback_source_select == 2'h0 |=> fb_ground_ff && power_down_ff)
    else $error("ground select did not flag power-down");
  chk_fb_route_one: assert property (@(posedge clk) disable iff (!rst_n)
    $onehot({fb_ground_ff, fb_vco_ff, fb_vco_dly_ff, fb_invalid_ff}))
    else $error("feedback route not one-hot");
  chk_fb_delayed: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && feedback_source_select == 2'h2 |=> fb_vco_dly_ff && !fb_vco_ff)
    else $error("delayed phase not routed");
  chk_fb_dly_val: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && feedback_delay_code == 5'h1f |=> fb_delay_ps_ff == 13'd5560)
    else $error("feedback delay code 31 wrong");
  chk_yb_dly_val: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && secondary_b_delay_code == 5'h01 |=> yb_delay_ps_ff == 13'd760)
    else $error("secondary delay code 1 wrong");
  chk_gl_dly_zero: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && global_a_delay_code == 5'h00 |=> gl_a_delay_ps_ff == 13'd225)
    else $error("global delay code 0 wrong");
  chk_gl_dly_two: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && global_c_delay_code == 5'h02 |=> gl_c_delay_ps_ff == 13'd920)
    else $error("global delay code 2 wrong");
  chk_osc_a_xtal: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && osc_path_a_select && dyn_source_a_select |=> ref_input_a_src_ff == 2'h2)
    else $error("input a crystal not chosen");
  chk_osc_bc_rc: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && osc_path_bc_select && !dyn_source_c_select |=> ref_input_c_src_ff == 2'h1)
    else $error("input c rc not chosen");
  chk_gmux_pair: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && glitchless_mux_config == 2'h2 && glitchless_out_mux |=> gmux_src_ff == 2'h2)
    else $error("glitchless mux pair wrong");
  // named steps: a frozen enable, and pair a/c with its select high
  sequence seq_frozen;
    !clk_en;
  endsequence
  sequence seq_cfg_a_c_hi;
    clk_en && glitchless_mux_config == 2'h0 && glitchless_out_mux;
  endsequence
  chk_fb_undelayed: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && feedback_source_select == 2'h1 |=> fb_vco_ff && !power_down_ff)
    else $error("undelayed phase not routed");
  chk_fb_rsvd_flag: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && feedback_source_select == 2'h3 |=> fb_invalid_ff && !fb_vco_ff && !fb_vco_dly_ff)
    else $error("reserved feedback select routed");
  chk_fb_dly_two: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && feedback_delay_code == 5'h02 |=> fb_delay_ps_ff == 13'd920)
    else $error("feedback delay code 2 wrong");
  chk_yc_dly_zero: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && secondary_c_delay_code == 5'h00 |=> yc_delay_ps_ff == 13'd600)
    else $error("secondary delay code 0 wrong");
  chk_glb_dly_one: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && global_b_delay_code == 5'h01 |=> gl_b_delay_ps_ff == 13'd760)
    else $error("global delay code 1 wrong");
  chk_osc_a_rc: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && osc_path_a_select && !dyn_source_a_select |=> ref_input_a_src_ff == 2'h1)
    else $error("input a rc not chosen");
  chk_osc_b_xtal: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && osc_path_bc_select && dyn_source_b_select |=> ref_input_b_src_ff == 2'h2)
    else $error("input b crystal not chosen");
  chk_gmux_a_c: assert property (@(posedge clk) disable iff (!rst_n)
    seq_cfg_a_c_hi |=> gmux_src_ff == 2'h1)
    else $error("glitchless pair a/c wrong");
  chk_gmux_a_int: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && glitchless_mux_config == 2'h1 && !glitchless_out_mux |=> gmux_src_ff == 2'h0)
    else $error("glitchless pair a/internal wrong");
  chk_gmux_rsvd: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && glitchless_mux_config == 2'h3 |=> gmux_src_ff == 2'h3 && gmux_cfg_invalid_ff)
    else $error("reserved glitchless config not flagged");
  // a low enable must leave the vco and reserved routes, the glitchless source and the feedback delay where they were
  chk_frozen_hold: assert property (@(posedge clk) disable iff (!rst_n)
    seq_frozen |=> $stable({fb_vco_ff, fb_invalid_ff, gmux_src_ff, fb_delay_ps_ff}))
    else $error("state moved while enable low");
endmodule

// ===== verification/ccd_ctrl_model.sv
`timescale 1ns/100ps
// ****************************************
// controlling logic model
// ****************************************
module ccd_ctrl_model (
  input  wire logic [1:0] fb_req,
  input  wire logic [1:0] gm_req,
  input  wire logic       rsvd_ok,
  output logic      [1:0] feedback_source_select,
  output logic      [1:0] glitchless_mux_config
);
  // reserved codes pass only when rsvd_ok is set; otherwise ground and pair a/c are substituted
  assign feedback_source_select = (fb_req == ccd_pkg::FB_SEL_RSVD && !rsvd_ok) ?
                                  ccd_pkg::FB_SEL_GROUND : fb_req;
  assign glitchless_mux_config  = (gm_req == ccd_pkg::GMX_CFG_RSVD && !rsvd_ok) ?
                                  ccd_pkg::GMX_CFG_A_C : gm_req;
endmodule

// ===== verification/test_clock_conditioning_config_decode.sv
`timescale 1ns/100ps
module test_clock_conditioning_config_decode;
  logic        clk, rst_n, clk_en, rsvd_ok, glitchless_out_mux;
  logic        osc_path_a_select, osc_path_bc_select;
  logic        dyn_source_a_select, dyn_source_b_select, dyn_source_c_select;
  logic [1:0]  fb_req, gm_req, feedback_source_select, glitchless_mux_config;
  logic [4:0]  feedback_delay_code, secondary_b_delay_code, secondary_c_delay_code;
  logic [4:0]  global_a_delay_code, global_b_delay_code, global_c_delay_code;
  logic        fb_ground_ff, fb_vco_ff, fb_vco_dly_ff, fb_invalid_ff, power_down_ff;
  logic        gmux_cfg_invalid_ff;
  logic [12:0] fb_delay_ps_ff, yb_delay_ps_ff, yc_delay_ps_ff;
  logic [12:0] gl_a_delay_ps_ff, gl_b_delay_ps_ff, gl_c_delay_ps_ff;
  logic [1:0]  ref_input_a_src_ff, ref_input_b_src_ff, ref_input_c_src_ff, gmux_src_ff;
  logic [4:0]  codes [4] = '{5'h00, 5'h01, 5'h02, 5'h1f};
  logic [1:0]  gm_exp [8] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h1, 2'h2, 2'h3, 2'h3};
  int          err_count, samples_checked;
  ccd_ctrl_model ctrl (.fb_req, .gm_req, .rsvd_ok, .feedback_source_select,
                       .glitchless_mux_config);
  ccd_config_decode dut (.clk, .rst_n, .clk_en, .feedback_source_select,
    .feedback_delay_code, .secondary_b_delay_code, .secondary_c_delay_code,
    .global_a_delay_code, .global_b_delay_code, .global_c_delay_code,
    .osc_path_a_select, .osc_path_bc_select, .dyn_source_a_select, .dyn_source_b_select,
    .dyn_source_c_select, .glitchless_mux_config, .glitchless_out_mux, .fb_ground_ff,
    .fb_vco_ff, .fb_vco_dly_ff, .fb_invalid_ff, .power_down_ff, .fb_delay_ps_ff,
    .yb_delay_ps_ff, .yc_delay_ps_ff, .gl_a_delay_ps_ff, .gl_b_delay_ps_ff, .gl_c_delay_ps_ff,
    .ref_input_a_src_ff, .ref_input_b_src_ff, .ref_input_c_src_ff, .gmux_src_ff,
    .gmux_cfg_invalid_ff);
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // inputs change 2 ns after an edge, so the next edge samples them cleanly
  task automatic cyc();
    @(posedge clk);
    #2;
  endtask
  function automatic logic [15:0] dly(input logic [4:0] c, input bit gl);
    return (gl && c == 5'h00) ? 16'h00e1 : 16'h0258 + 16'h00a0 * c;
  endfunction
  function automatic logic [1:0] src(input logic p, input logic d);
    return !p ? ccd_pkg::OSC_SRC_PIN : (d ? ccd_pkg::OSC_SRC_XTAL : ccd_pkg::OSC_SRC_RC);
  endfunction
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ****************************************
  // clock, watchdog and tests
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #(25 * 2000);
    err_count++;
    stop_test();
  end
  initial begin
    {rst_n, clk_en, rsvd_ok, glitchless_out_mux, fb_req, gm_req} = '0;
    {osc_path_a_select, osc_path_bc_select} = '0;
    {dyn_source_a_select, dyn_source_b_select, dyn_source_c_select} = '0;
    {feedback_delay_code, secondary_b_delay_code, secondary_c_delay_code} = '0;
    {global_a_delay_code, global_b_delay_code, global_c_delay_code} = '0;
    err_count = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk);
    #2;
    rst_n = 1'b1;
    check(power_down_ff, 1'b1);
    check(gl_a_delay_ps_ff, 16'h00e1);
    clk_en = 1'b1;
    rsvd_ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      fb_req = 2'(i);
      cyc();
      check({fb_ground_ff, fb_vco_ff, fb_vco_dly_ff, fb_invalid_ff}, 4'h8 >> i);
      check(power_down_ff, i == 0);
    end
    // a frozen enable must hold the reserved-select flag
    clk_en = 1'b0;
    fb_req = 2'h1;
    cyc();
    check({fb_vco_ff, fb_invalid_ff}, 2'h1);
    clk_en = 1'b1;
    foreach (codes[k]) begin
      {feedback_delay_code, secondary_c_delay_code} = {2{codes[k]}};
      {global_a_delay_code, global_c_delay_code} = {2{codes[k]}};
      {secondary_b_delay_code, global_b_delay_code} = {2{codes[3-k]}};
      cyc();
      check(fb_delay_ps_ff, dly(codes[k], 1'b0));
      check(yb_delay_ps_ff, dly(codes[3-k], 1'b0));
      check(yc_delay_ps_ff, dly(codes[k], 1'b0));
      check(gl_a_delay_ps_ff, dly(codes[k], 1'b1));
      check(gl_b_delay_ps_ff, dly(codes[3-k], 1'b1));
      check(gl_c_delay_ps_ff, dly(codes[k], 1'b1));
    end
    for (int i = 0; i < 8; i++) begin
      {osc_path_a_select, osc_path_bc_select} = {i[2], i[1]};
      {dyn_source_a_select, dyn_source_b_select, dyn_source_c_select} = {i[0], i[0], !i[0]};
      cyc();
      check(ref_input_a_src_ff, src(i[2], i[0]));
      check(ref_input_b_src_ff, src(i[1], i[0]));
      check(ref_input_c_src_ff, src(i[1], !i[0]));
    end
    for (int i = 0; i < 8; i++) begin
      gm_req = 2'(i >> 1);
      glitchless_out_mux = i[0];
      cyc();
      check(gmux_src_ff, gm_exp[i]);
      check(gmux_cfg_invalid_ff, i >= 6);
    end
    // a second reset in mid-run must restore ground, vco and power-down, the feedback and global c delays, input b and the glitchless mux
    rst_n = 1'b0;
    cyc();
    check({fb_ground_ff, fb_vco_ff, power_down_ff}, 3'h5);
    check(fb_delay_ps_ff, 16'h0258);
    check(gl_c_delay_ps_ff, 16'h00e1);
    check(ref_input_b_src_ff, ccd_pkg::OSC_SRC_PIN);
    check({gmux_src_ff, gmux_cfg_invalid_ff}, {ccd_pkg::GMX_SRC_A, 1'b0});
    // reserved codes refused: the controller falls back to ground and pair a/c
    rst_n = 1'b1;
    rsvd_ok = 1'b0;
    {fb_req, gm_req} = {ccd_pkg::FB_SEL_RSVD, ccd_pkg::GMX_CFG_RSVD};
    glitchless_out_mux = 1'b1;
    cyc();
    check(feedback_source_select, ccd_pkg::FB_SEL_GROUND);
    check({power_down_ff, fb_invalid_ff}, 2'h2);
    check({gmux_src_ff, gmux_cfg_invalid_ff}, {ccd_pkg::GMX_SRC_C, 1'b0});
    stop_test();
  end
endmodule
